// >>> bufctl_consts.svh
// Offsets, field positions, reset values and sizes for the buffer status block
`ifndef BUFCTL_CONSTS_SVH
`define BUFCTL_CONSTS_SVH
`define NUM_BUF          32
`define NUM_CTRL_REGS    16
`define OFF_FULL_LO      8'h00
`define OFF_FULL_HI      8'h04
`define OFF_OVF_LO       8'h08
`define OFF_OVF_HI       8'h0C
`define OFF_IRQ_STATUS   8'h10
`define OFF_IRQ_ENABLE   8'h14
`define OFF_IRQ_CLEAR    8'h18
`define OFF_CTRL_BASE    8'h40
`define CTRL_DIR_BIT     7
`define CTRL_ABT_BIT     6
`define CTRL_LARB_BIT    5
`define CTRL_ERR_BIT     4
`define CTRL_REQ_BIT     3
`define CTRL_RTR_BIT     2
`define CTRL_SW_MASK     8'h8F
`define CTRL_RESET       8'h00
`define FLAGS_RESET      16'h0000
`define IRQ_RX_STORED    0
`define IRQ_OVERFLOW     1
`define IRQ_SENT         2
`define IRQ_SEND_FAIL    3
`define IRQ_BITS         4
`endif

// >>> bufctl_pkg.sv
// Types for the buffer status block
package bufctl_pkg;
	typedef struct packed {
		logic       dir_tx;
		logic       aborted;
		logic       arb_lost;
		logic       send_err;
		logic       send_req;
		logic       rtr_en;
		logic [1:0] prio;
	} buf_ctrl_t;
	typedef struct packed {
		logic       valid;
		logic [4:0] index;
	} buf_event_t;
	typedef struct packed {
		logic       valid;
		logic [4:0] index;
		logic       ok;
		logic       aborted;
		logic       arb_lost;
		logic       bus_err;
	} tx_result_t;
	typedef enum logic [1:0] {ST_IDLE, ST_ANSWER} bus_state_t;
endpackage : bufctl_pkg

// >>> can_msg_buffer_status_ctrl.sv
// Status and control registers for the 32 message buffers of a CAN controller
//
// The Avalon-MM slave port and the address map are this design's own decisions.
`timescale 1ns/100ps
`include "bufctl_consts.svh"
module can_msg_buffer_status_ctrl
	import bufctl_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        srst,
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	input  wire buf_event_t  rx_store,
	output buf_event_t       tx_pick,
	input  wire tx_result_t  tx_done,
	output logic [31:0]      rx_eligible,
	output logic             irq
);

	buf_ctrl_t                ctrl_reg [`NUM_BUF];
	logic [`NUM_BUF-1:0]      full_reg;
	logic [`NUM_BUF-1:0]      ovf_reg;
	logic [`IRQ_BITS-1:0]     irq_status_reg;
	logic [`IRQ_BITS-1:0]     irq_enable_reg;
	bus_state_t               bus_state_reg;
	logic [31:0]              rdata_next;
	logic                     wr_go;
	logic [31:0]              wmask;
	logic [`NUM_BUF-1:0]      full_clr;
	logic [`NUM_BUF-1:0]      ovf_clr;
	logic [`NUM_BUF-1:0]      store_hit;
	logic [`NUM_BUF-1:0]      done_hit;
	logic [`IRQ_BITS-1:0]     irq_set;
	logic [`IRQ_BITS-1:0]     irq_clr;
	buf_event_t               pick_next;
	logic                     new_pick;
	logic                     sel_full_lo;
	logic                     sel_full_hi;
	logic                     sel_ovf_lo;
	logic                     sel_ovf_hi;
	logic                     sel_ctrl;
	logic                     sel_irq_en;
	logic                     sel_irq_clr;

	// Bytes enabled in a write
	function automatic logic [31:0] lane_mask(input logic [3:0] be);
		lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction : lane_mask

	// True when the address selects a given word
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
		hit = (addr == off);
	endfunction : hit

	// True when the address selects a control pair word
	function automatic logic ctrl_hit(input logic [7:0] addr);
		ctrl_hit = (addr[7:6] == 2'b01) && (addr[1:0] == 2'b00);
	endfunction : ctrl_hit

	// Avalon slave: one wait cycle, answer in the second cycle of a request
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			bus_state_reg <= ST_IDLE;
		end else begin
			unique case (bus_state_reg)
				ST_IDLE: begin
					if (avs_read || avs_write) begin
						bus_state_reg <= ST_ANSWER;
					end
				end
				ST_ANSWER: begin
					bus_state_reg <= ST_IDLE;
				end
				default: begin
					bus_state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// Wait line: low only in the answer cycle of a request
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			avs_waitrequest <= 1'b1;
		end else begin
			avs_waitrequest <= !(bus_state_reg == ST_IDLE && (avs_read || avs_write));
		end
	end

	assign wr_go           = avs_write && (bus_state_reg == ST_ANSWER);
	assign wmask           = lane_mask(avs_byteenable);

	// Register word selects
	assign sel_full_lo     = hit(avs_address, `OFF_FULL_LO);
	assign sel_full_hi     = hit(avs_address, `OFF_FULL_HI);
	assign sel_ovf_lo      = hit(avs_address, `OFF_OVF_LO);
	assign sel_ovf_hi      = hit(avs_address, `OFF_OVF_HI);
	assign sel_irq_en      = hit(avs_address, `OFF_IRQ_ENABLE);
	assign sel_irq_clr     = hit(avs_address, `OFF_IRQ_CLEAR);
	assign sel_ctrl        = ctrl_hit(avs_address);

	// Read data: full and overflow flags, interrupt registers, control pairs
	always_comb begin
		rdata_next = 32'h0000_0000;
		if (sel_full_lo) begin
			rdata_next[15:0] = full_reg[15:0];
		end else if (sel_full_hi) begin
			rdata_next[15:0] = full_reg[31:16];
		end else if (sel_ovf_lo) begin
			rdata_next[15:0] = ovf_reg[15:0];
		end else if (sel_ovf_hi) begin
			rdata_next[15:0] = ovf_reg[31:16];
		end else if (hit(avs_address, `OFF_IRQ_STATUS)) begin
			rdata_next[`IRQ_BITS-1:0] = irq_status_reg;
		end else if (sel_irq_en) begin
			rdata_next[`IRQ_BITS-1:0] = irq_enable_reg;
		end else if (sel_ctrl) begin
			rdata_next[15:0] = {ctrl_reg[{avs_address[5:2], 1'b1}],
				ctrl_reg[{avs_address[5:2], 1'b0}]};
		end
	end

	// Read data register; zero for unmapped words, holds its last value on writes
	logic [31:0] rdata_reg;
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rdata_reg <= 32'h0000_0000;
		end else if (avs_read && bus_state_reg == ST_IDLE) begin
			rdata_reg <= rdata_next;
		end
	end
	assign avs_readdata = rdata_reg;

	// Software clears: writing one to a flag bit clears it, zero leaves it
	always_comb begin
		full_clr = '0;
		ovf_clr  = '0;
		if (wr_go && sel_full_lo) begin
			full_clr[15:0] = avs_writedata[15:0] & wmask[15:0];
		end
		if (wr_go && sel_full_hi) begin
			full_clr[31:16] = avs_writedata[15:0] & wmask[15:0];
		end
		if (wr_go && sel_ovf_lo) begin
			ovf_clr[15:0] = avs_writedata[15:0] & wmask[15:0];
		end
		if (wr_go && sel_ovf_hi) begin
			ovf_clr[31:16] = avs_writedata[15:0] & wmask[15:0];
		end
	end

	// Per-buffer decode of incoming store and send result
	genvar g;
	generate
		for (g = 0; g < `NUM_BUF; g++) begin : g_buf
			assign store_hit[g] = rx_store.valid && rx_store.index == 5'(g)
				&& !ctrl_reg[g].dir_tx;
			assign done_hit[g]  = tx_done.valid && tx_done.index == 5'(g)
				&& ctrl_reg[g].dir_tx;
			always_ff @(posedge sys_clk) begin
				if (srst) begin
					rx_eligible[g] <= 1'b1;
				end else begin
					rx_eligible[g] <= !ctrl_reg[g].dir_tx;
				end
			end
		end
	endgenerate

	// Full flags: set wins over a clear in the same cycle
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			full_reg <= {`FLAGS_RESET, `FLAGS_RESET};
		end else begin
			full_reg <= (full_reg & ~full_clr) | store_hit;
		end
	end

	// Overflow flags: store directed at a buffer already full
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			ovf_reg <= {`FLAGS_RESET, `FLAGS_RESET};
		end else begin
			ovf_reg <= (ovf_reg & ~ovf_clr) | (store_hit & full_reg);
		end
	end

	// Control fields: software writes mode bits; hardware owns the status bits
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			for (int i = 0; i < `NUM_BUF; i++) begin
				ctrl_reg[i] <= `CTRL_RESET;
			end
		end else begin
			for (int i = 0; i < `NUM_BUF; i++) begin
				if (wr_go && sel_ctrl && avs_address[5:2] == 4'(i >> 1)
					&& avs_byteenable[i % 2]) begin
					ctrl_reg[i] <= (ctrl_reg[i] & ~`CTRL_SW_MASK)
						| (avs_writedata[(i % 2) * 8 +: 8] & `CTRL_SW_MASK);
				end
				if (new_pick && pick_next.index == 5'(i)) begin
					ctrl_reg[i].aborted  <= 1'b0;
					ctrl_reg[i].arb_lost <= 1'b0;
					ctrl_reg[i].send_err <= 1'b0;
				end
				if (done_hit[i]) begin
					ctrl_reg[i].aborted  <= tx_done.aborted;
					ctrl_reg[i].arb_lost <= tx_done.arb_lost;
					ctrl_reg[i].send_err <= tx_done.bus_err;
					if (tx_done.ok || tx_done.aborted) begin
						ctrl_reg[i].send_req <= 1'b0;
					end
				end
			end
		end
	end

	// Pick highest priority pending transmit buffer; lower index breaks ties
	always_comb begin
		logic [1:0] best;
		best      = 2'b00;
		pick_next = '0;
		for (int i = 0; i < `NUM_BUF; i++) begin
			if (ctrl_reg[i].dir_tx && ctrl_reg[i].send_req
				&& (!pick_next.valid || ctrl_reg[i].prio > best)) begin
				pick_next.valid = 1'b1;
				pick_next.index = 5'(i);
				best            = ctrl_reg[i].prio;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			tx_pick <= '0;
		end else begin
			tx_pick <= pick_next;
		end
	end

	// A buffer newly chosen; outcome bits then hold through retries
	assign new_pick = pick_next.valid && !(tx_pick.valid && tx_pick.index == pick_next.index);

	// Interrupt events, sticky status, enable and write-one clear
	assign irq_set[`IRQ_RX_STORED] = |store_hit;
	assign irq_set[`IRQ_OVERFLOW]  = |(store_hit & full_reg);
	assign irq_set[`IRQ_SENT]      = |done_hit && tx_done.ok;
	assign irq_set[`IRQ_SEND_FAIL] = |done_hit && !tx_done.ok;
	assign irq_clr = (wr_go && sel_irq_clr)
		? avs_writedata[`IRQ_BITS-1:0] & wmask[`IRQ_BITS-1:0] : '0;

	// Sticky status bits: an event wins over a clear in the same cycle
	generate
		for (g = 0; g < `IRQ_BITS; g++) begin : g_irq
			always_ff @(posedge sys_clk) begin
				if (srst) begin
					irq_status_reg[g] <= 1'b0;
				end else if (irq_set[g]) begin
					irq_status_reg[g] <= 1'b1;
				end else if (irq_clr[g]) begin
					irq_status_reg[g] <= 1'b0;
				end
			end
		end
	endgenerate

	// Enable register, byte lanes honoured
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			irq_enable_reg <= '0;
		end else if (wr_go && sel_irq_en) begin
			irq_enable_reg <= (avs_writedata[`IRQ_BITS-1:0] & wmask[`IRQ_BITS-1:0])
				| (irq_enable_reg & ~wmask[`IRQ_BITS-1:0]);
		end
	end

	// Level interrupt from the status as it stands after this edge
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(((irq_status_reg & ~irq_clr) | irq_set) & irq_enable_reg);
		end
	end

	// Buffer words themselves sit in DMA RAM outside this block

endmodule : can_msg_buffer_status_ctrl

// >>> can_msg_buffer_status_ctrl_monitor.sv
// Checker for the buffer status block
`timescale 1ns/100ps
module bufctl_monitor
	import bufctl_pkg::*;
(
	input logic        sys_clk,
	input logic        srst,
	input logic [7:0]  avs_address,
	input logic        avs_read,
	input logic        avs_write,
	input logic [31:0] avs_writedata,
	input logic [3:0]  avs_byteenable,
	input logic [31:0] avs_readdata,
	input logic        avs_waitrequest,
	input buf_event_t  rx_store,
	input buf_event_t  tx_pick,
	input tx_result_t  tx_done,
	input logic [31:0] rx_eligible,
	input logic        irq
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	rst_vals_a: assert property ($fell(srst) |-> &rx_eligible && !irq && !tx_pick.valid)
		else $error("reset values wrong");
	bus_answer_a: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
		else $error("no answer after one wait");
	answer_once_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("answer longer than one cycle");
	upper_zero_a: assert property (avs_read && !avs_waitrequest && avs_address < 8'h10
		|-> avs_readdata[31:16] == 16'h0000) else $error("flag word upper half set");
	dir_low_a: assert property (avs_write && !avs_waitrequest && avs_address == 8'h40
		&& avs_byteenable[0] |=> ##1 rx_eligible[0] == !$past(avs_writedata[7], 2))
		else $error("buffer 0 direction wrong");
	dir_high_a: assert property (avs_write && !avs_waitrequest && avs_address == 8'h40
		&& avs_byteenable[1] |=> ##1 rx_eligible[1] == !$past(avs_writedata[15], 2))
		else $error("buffer 1 direction wrong");
	pick_tx_a: assert property (tx_pick.valid |-> !rx_eligible[tx_pick.index])
		else $error("receive buffer picked");
	sent_clear_a: assert property (tx_done.valid && tx_done.ok && tx_pick.valid
		|=> ##1 tx_pick != $past(tx_pick, 2)) else $error("sent buffer still picked");
endmodule : bufctl_monitor
bind can_msg_buffer_status_ctrl bufctl_monitor mon (.*);

// >>> can_node_model.sv
// Far-side node model: stores messages and reports send outcomes
`timescale 1ns/100ps
module can_node_model
	import bufctl_pkg::*;
(
	input  logic       sys_clk,
	input  logic       srst,
	input  buf_event_t store_cmd,
	input  logic       lose_arb,
	input  buf_event_t tx_pick,
	output buf_event_t rx_store,
	output tx_result_t tx_done
);
	logic [1:0] wait_reg;
	always_ff @(posedge sys_clk) begin
		rx_store <= srst ? '0 : store_cmd;
	end
	always_ff @(posedge sys_clk) begin
		tx_done <= '0;
		if (srst || !tx_pick.valid || tx_done.valid) begin
			wait_reg <= 2'd0;
		end else begin
			wait_reg <= wait_reg + 2'd1;
			if (wait_reg == 2'd3) begin
				tx_done <= '{1'b1, tx_pick.index, !lose_arb, 1'b0, lose_arb, 1'b0};
			end
		end
	end
endmodule : can_node_model

// >>> can_msg_buffer_status_ctrl_test.sv
// Self-checking bench for the buffer status block
`timescale 1ns/100ps
module can_msg_buffer_status_ctrl_test
	import bufctl_pkg::*;
;
	logic        sys_clk = 0, srst = 1, avs_read = 0, avs_write = 0, irq, lose_arb = 1;
	logic [7:0]  avs_address = 0;
	logic [31:0] avs_writedata = 0, avs_readdata, rx_eligible, rd;
	logic [3:0]  avs_byteenable = 0;
	logic        avs_waitrequest;
	buf_event_t  rx_store, tx_pick, store_cmd = '0;
	tx_result_t  tx_done;
	int          error_cnt, tests_run, cyc;
	can_msg_buffer_status_ctrl dut (.sys_clk(sys_clk), .srst(srst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .rx_store(rx_store), .tx_pick(tx_pick),
		.tx_done(tx_done), .rx_eligible(rx_eligible), .irq(irq));
	can_node_model node (.sys_clk(sys_clk), .srst(srst), .store_cmd(store_cmd),
		.lose_arb(lose_arb), .tx_pick(tx_pick), .rx_store(rx_store), .tx_done(tx_done));
	always #25 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			conclude();
		end
	end
	task conclude;
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : conclude
	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		tests_run++;
		if (s !== e) begin
			$display("mismatch %s expected %h seen %h", n, e, s);
			error_cnt++;
		end
	endtask : chk
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
		@(posedge sys_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_write <= w;
		avs_read <= !w;
		do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : bus
	task rchk(input string n, input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000, 4'hF);
		chk(n, e, rd);
	endtask : rchk
	task store(input logic [4:0] i);
		@(posedge sys_clk);
		store_cmd <= '{1'b1, i};
		@(posedge sys_clk);
		store_cmd <= '0;
		repeat (2) @(negedge sys_clk);
	endtask : store
	task t_reset;
		for (int a = 0; a < 8'h18; a += 4) rchk("reset word", a[7:0], 32'h0000_0000);
		rchk("reset control", 8'h40, 32'h0000_0000);
		$display("reset test done");
	endtask : t_reset
	task t_rx;
		store(5'd3);
		store(5'd20);
		rchk("full low", 8'h00, 32'h0000_0008);
		rchk("full high", 8'h04, 32'h0000_0010);
		chk("irq masked", 32'h0, irq);
		store(5'd3);
		store(5'd20);
		rchk("ovf low", 8'h08, 32'h0000_0008);
		rchk("ovf high", 8'h0C, 32'h0000_0010);
		bus(1'b1, 8'h00, 32'h0000_FFFF, 4'hF);
		rchk("full low clear", 8'h00, 32'h0000_0000);
		store(5'd3);
		rchk("ovf kept", 8'h08, 32'h0000_0008);
		bus(1'b1, 8'h08, 32'h0000_FFFF, 4'hF);
		rchk("ovf low clear", 8'h08, 32'h0000_0000);
		bus(1'b1, 8'h14, 32'h0000_0002, 4'hF);
		repeat (2) @(negedge sys_clk);
		chk("irq on", 32'h1, irq);
		bus(1'b1, 8'h18, 32'h0000_0002, 4'hF);
		repeat (2) @(negedge sys_clk);
		chk("irq off", 32'h0, irq);
		$display("receive test done");
	endtask : t_rx
	task t_tx;
		bus(1'b1, 8'h40, 32'h0000_0089, 4'h1);
		repeat (2) @(negedge sys_clk);
		chk("receive map", 32'hFFFF_FFFE, rx_eligible);
		chk("pick", {1'b1, 5'd0}, tx_pick);
		store(5'd0);
		rchk("tx store ignored", 8'h00, 32'h0000_0008);
		repeat (8) @(posedge sys_clk);
		rchk("arb lost", 8'h40, 32'h0000_00A9);
		lose_arb <= 1'b0;
		repeat (12) @(negedge sys_clk);
		chk("pick idle", 32'h0, tx_pick);
		bus(1'b1, 8'h40, 32'h0000_7000, 4'h2);
		rchk("control", 8'h40, 32'h0000_0081);
		rchk("status", 8'h10, 32'h0000_000D);
		$display("transmit test done");
	endtask : t_tx
	initial begin
		repeat (2) @(posedge sys_clk);
		srst <= 1'b0;
		t_reset();
		t_rx();
		t_tx();
		conclude();
	end
endmodule : can_msg_buffer_status_ctrl_test
